/* File: rtl/bfs_top.sv */
/*
  Buck fault sequencer top: start-up, pre-bias, over-current hiccup,
  negative current limit, thermal and power-good logic. Assumes the analog
  comparators appear as digital flags and the power stage takes gate levels.
*/
// Contract
// - Switch only while supply and bias lockout comparators both report OK.
// - Lockout thresholds have hysteresis; the comparator provides it, we just follow.
// - Enable high with lockouts clear starts the soft-start sequence.
// - Enable below deep threshold gives deep shutdown with bias off.
// - Without soft-start capacitor use fixed timed start-up, never shorter.
// - Keep gates quiet until soft-start exceeds feedback, then switch.
// - Never switch while output is pre-biased above nominal.
// - Over-current turns high-side off for the rest of the cycle.
// - Count over-current events; clear after 32 clean cycles.
// - Reaching five events inside the window enters hiccup.
// - Hiccup waits a fixed time then restarts.
// - Hiccup entry: high-side off, low-side on until zero current, then both off.
// - Hiccup entry asserts soft-start discharge.
// - Negative limit only under over-voltage; trip turns low-side off.
// - Power good low on current limit, lockout, OV, UV or unregulated.
// - Every power-good change passes the deglitch filter.
// - Over-temperature holds both gates off.
// - Over-temperature holds power good low.
// - Discharge soft-start on enable cycling, lockout, over-temperature, hiccup.
// - Power good high needs output good and soft-start above its threshold.
module bfs_top #(
  parameter int unsigned SS_CYC = bfs_pkg::SS_CYCLES,
  parameter int unsigned DGL_CYC = bfs_pkg::DGL_CYCLES,
  parameter int unsigned OC_WIN = bfs_pkg::OC_WINDOW,
  parameter int unsigned OC_TRIP_N = bfs_pkg::OC_TRIP
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic input_supply_ok,
  input wire logic bias_rail_ok,
  input wire logic enable_on,
  input wire logic enable_deep_low,
  input wire logic ss_cap_present,
  input wire logic ss_above_feedback_level,
  input wire logic output_prebias_high,
  input wire logic over_current,
  input wire logic over_voltage,
  input wire logic under_voltage,
  input wire logic output_unregulated,
  input wire logic over_temp,
  input wire logic switch_node_neg_trip,
  input wire logic inductor_zero,
  input wire logic ss_pg_level_ok,
  input wire logic output_pg_level_ok,
  input wire logic pwm_cycle_start,
  input wire logic pwm_demand,
  output logic high_gate,
  output logic low_gate,
  output logic ss_discharge,
  output logic bias_on,
  output logic power_good_out,
  output logic hiccup_active,
  output logic [2:0] seq_state
);
  localparam int unsigned NF = 16;

  typedef struct packed {
    bfs_pkg::bfs_state_t state;
    logic [bfs_pkg::CNT_W-1:0] tmr;
    logic [5:0] clean;
    logic [2:0] oc_cnt;
    logic hs_block;
    logic ls_block;
    logic en_prev;
    logic hg;
    logic lg;
    logic dis;
  } bfs_st_t;

  bfs_st_t st_ff;
  bfs_st_t nxt_st;
  logic [NF-1:0] raw;
  logic [NF-1:0] syn;
  logic pg_raw;
  logic lockout_ok;
  bfs_flags_if fl ();

  // All comparator flags except pwm_demand and ss_cap_present cross into the clock domain together.
  assign raw = {pwm_cycle_start, output_pg_level_ok, ss_pg_level_ok, inductor_zero,
    switch_node_neg_trip, over_temp, output_unregulated, under_voltage, over_voltage,
    over_current, output_prebias_high, ss_above_feedback_level, enable_deep_low,
    enable_on, bias_rail_ok, input_supply_ok};

  bfs_sync #(.N(NF)) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .raw(raw),
    .synced(syn)
  );

  // Unpack the synchronised bank into named flags.
  assign fl.supply_ok = syn[0];
  assign fl.bias_ok = syn[1];
  assign fl.en_on = syn[2];
  assign fl.en_deep = syn[3];
  assign fl.ss_over_feedback = syn[4];
  assign fl.prebias_high = syn[5];
  assign fl.oc_event = syn[6];
  assign fl.ov_fault = syn[7];
  assign fl.uv_fault = syn[8];
  assign fl.unreg = syn[9];
  assign fl.ot_fault = syn[10];
  assign fl.neg_trip = syn[11];
  assign fl.zero_cur = syn[12];
  assign fl.ss_pg_ok = syn[13];
  assign fl.out_pg_ok = syn[14];
  assign fl.cycle_start = syn[15];

  // Hysteresis is analog; the digital side only reads the comparator level.
  assign lockout_ok = fl.supply_ok && fl.bias_ok;

  // Sequencer, over-current counter and gate control in one next-state block.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.en_prev = fl.en_on;
    nxt_st.dis = 1'b0;
    nxt_st.hg = 1'b0;
    nxt_st.lg = 1'b0;
    case (st_ff.state)
      bfs_pkg::BFS_SHDN: begin
        nxt_st.dis = 1'b1;
        nxt_st.oc_cnt = '0;
        nxt_st.clean = '0;
        nxt_st.tmr = '0;
        if (fl.en_on && !fl.en_deep && lockout_ok && !fl.ot_fault) begin
          nxt_st.state = bfs_pkg::BFS_INIT;
        end
      end
      bfs_pkg::BFS_INIT: begin
        // Short delay lets internal circuitry settle before soft-start.
        if (st_ff.tmr >= bfs_pkg::CNT_W'(bfs_pkg::INIT_CYCLES - 1)) begin
          nxt_st.tmr = '0;
          nxt_st.state = bfs_pkg::BFS_SOFT;
        end else begin
          nxt_st.tmr = st_ff.tmr + 1'b1;
        end
      end
      bfs_pkg::BFS_SOFT: begin
        // Timed ramp still runs with a capacitor: start-up is never faster.
        if (st_ff.tmr < bfs_pkg::CNT_W'(SS_CYC)) begin
          nxt_st.tmr = st_ff.tmr + 1'b1;
        end
        if (fl.ss_over_feedback && !fl.prebias_high) begin
          nxt_st.hg = pwm_demand && !st_ff.hs_block;
          nxt_st.lg = !pwm_demand && !st_ff.ls_block;
        end
        if (st_ff.tmr >= bfs_pkg::CNT_W'(SS_CYC) && fl.ss_over_feedback && (ss_cap_present
            || !fl.prebias_high)) begin
          nxt_st.state = bfs_pkg::BFS_RUN;
        end
      end
      bfs_pkg::BFS_RUN: begin
        if (!fl.prebias_high) begin
          nxt_st.hg = pwm_demand && !st_ff.hs_block;
          nxt_st.lg = !pwm_demand && !st_ff.ls_block;
        end
      end
      bfs_pkg::BFS_HIC_DRAIN: begin
        // Low-side drains the inductor, then the switch node floats.
        nxt_st.dis = 1'b1;
        nxt_st.lg = !fl.zero_cur && !(fl.ov_fault && fl.neg_trip);
        if (fl.zero_cur) begin
          nxt_st.lg = 1'b0;
          nxt_st.tmr = '0;
          nxt_st.state = bfs_pkg::BFS_HIC_WAIT;
        end
      end
      bfs_pkg::BFS_HIC_WAIT: begin
        nxt_st.dis = 1'b1;
        if (st_ff.tmr >= bfs_pkg::CNT_W'(SS_CYC - 1)) begin
          nxt_st.tmr = '0;
          nxt_st.oc_cnt = '0;
          nxt_st.state = bfs_pkg::BFS_SOFT;
        end else begin
          nxt_st.tmr = st_ff.tmr + 1'b1;
        end
      end
      default: begin
        nxt_st.state = bfs_pkg::BFS_SHDN;
      end
    endcase

    // Over-current blanking lasts to the next cycle; the event wins a tie.
    if (fl.cycle_start) begin
      nxt_st.hs_block = 1'b0;
      nxt_st.ls_block = 1'b0;
    end
    if (fl.oc_event) begin
      nxt_st.hs_block = 1'b1;
      nxt_st.hg = 1'b0;
    end
    if (fl.ov_fault && fl.neg_trip && st_ff.lg) begin
      nxt_st.ls_block = 1'b1;
      nxt_st.lg = 1'b0;
    end

    // Event counter over switching cycles in the active states.
    if (st_ff.state == bfs_pkg::BFS_SOFT || st_ff.state == bfs_pkg::BFS_RUN) begin
      if (fl.oc_event && !st_ff.hs_block) begin
        nxt_st.clean = '0;
        if (st_ff.oc_cnt >= 3'(OC_TRIP_N - 1)) begin
          nxt_st.state = bfs_pkg::BFS_HIC_DRAIN;
          nxt_st.hg = 1'b0;
          nxt_st.lg = 1'b1;
          nxt_st.dis = 1'b1;
          nxt_st.oc_cnt = '0;
        end else begin
          nxt_st.oc_cnt = st_ff.oc_cnt + 1'b1;
        end
      end else if (fl.cycle_start && !st_ff.hs_block) begin
        if (st_ff.clean >= 6'(OC_WIN - 1)) begin
          nxt_st.clean = '0;
          nxt_st.oc_cnt = '0;
        end else begin
          nxt_st.clean = st_ff.clean + 1'b1;
        end
      end else if (fl.cycle_start) begin
        nxt_st.clean = '0;
      end
    end

    // Faults that drop back to shutdown, discharging soft-start.
    if (!lockout_ok || fl.ot_fault || !fl.en_on || fl.en_deep || (st_ff.en_prev
        && !fl.en_on)) begin
      nxt_st.state = bfs_pkg::BFS_SHDN;
      nxt_st.dis = 1'b1;
      nxt_st.hg = 1'b0;
      nxt_st.lg = 1'b0;
    end
  end

  // Registered state; clk_en freezes everything.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // Raw power-good: all faults force low, and only a full ramp lets it rise.
  assign pg_raw = st_ff.state == bfs_pkg::BFS_RUN && fl.out_pg_ok && fl.ss_pg_ok
    && !st_ff.hs_block && lockout_ok && !fl.ov_fault && !fl.uv_fault
    && !fl.unreg && !fl.ot_fault;

  bfs_pg_filter #(.DGL(DGL_CYC)) u_pgf (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .pg_raw(pg_raw),
    .pg_filt(power_good_out)
  );

  assign high_gate = st_ff.hg;
  assign low_gate = st_ff.lg;
  assign ss_discharge = st_ff.dis;
  assign bias_on = !fl.en_deep;
  assign hiccup_active = st_ff.state == bfs_pkg::BFS_HIC_DRAIN ||
    st_ff.state == bfs_pkg::BFS_HIC_WAIT;
  assign seq_state = st_ff.state;

  // Next-cycle (|=>) antecedents carry clk_en, since a frozen cycle must not be judged on the next edge.
  a_gates_lockout: assert property (@(posedge sys_clk) disable iff (!nrst)
    !lockout_ok && clk_en |=> !high_gate && !low_gate)
    else $error("Gate active during lockout.");
  a_gates_overtemp: assert property (@(posedge sys_clk) disable iff (!nrst)
    fl.ot_fault && clk_en |=> !high_gate && !low_gate)
    else $error("Gate active during over-temperature.");
  a_hs_oc_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    fl.oc_event && clk_en |=> !high_gate)
    else $error("High-side on after over-current.");
  a_no_prebias_switch: assert property (@(posedge sys_clk) disable iff (!nrst)
    fl.prebias_high && clk_en && st_ff.state != bfs_pkg::BFS_HIC_DRAIN |=> !high_gate)
    else $error("Switching while pre-biased.");
  a_hiccup_dis: assert property (@(posedge sys_clk) disable iff (!nrst)
    hiccup_active |-> ss_discharge && !high_gate)
    else $error("Hiccup without discharge.");
  a_soft_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_ff.state == bfs_pkg::BFS_SOFT && !fl.ss_over_feedback && clk_en |=> !high_gate)
    else $error("Switching before soft-start passed feedback.");
  a_pg_hiccup_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    hiccup_active |-> !pg_raw)
    else $error("Power good request during hiccup.");
  a_pg_temp_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    fl.ot_fault |-> !pg_raw)
    else $error("Power good request during over-temperature.");
  a_run_timed: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_ff.state == bfs_pkg::BFS_SOFT && nxt_st.state == bfs_pkg::BFS_RUN && clk_en
    |-> st_ff.tmr >= bfs_pkg::CNT_W'(SS_CYC))
    else $error("Start-up shorter than fixed time.");
  a_neg_limit_ov: assert property (@(posedge sys_clk) disable iff (!nrst)
    !fl.ov_fault && !st_ff.ls_block && clk_en |=> !st_ff.ls_block)
    else $error("Negative limit armed without over-voltage.");
  a_hic_entry_ls: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(hiccup_active) |-> low_gate && !high_gate)
    else $error("Hiccup entry without low-side drain.");
  a_oc_window_clr: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && st_ff.state == bfs_pkg::BFS_RUN && fl.cycle_start && !fl.oc_event
    && !st_ff.hs_block && st_ff.clean == 6'(OC_WIN - 1) |=> st_ff.oc_cnt == 3'h0)
    else $error("Over-current count kept after a clean window.");
endmodule

/* File: rtl/bfs_pkg.sv */
/*
  Package of the buck fault sequencer: timing counts, thresholds and the
  sequencer states. Assumes a 100 MHz system clock.
*/
package bfs_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Digital start-up and hiccup wait time, in hundredths of a microsecond (1.28 ms).
  localparam int unsigned T_SS_US_X100 = 128000;
  localparam int unsigned SS_CYCLES = (T_SS_US_X100 * CLK_MHZ) / 100;
  // Power-good deglitch time in microseconds.
  localparam int unsigned T_DEGLITCH_US = 20;
  localparam int unsigned DGL_CYCLES = T_DEGLITCH_US * CLK_MHZ;
  // Over-current window and trip count.
  localparam int unsigned OC_WINDOW = 32;
  localparam int unsigned OC_TRIP = 5;
  // Initialisation delay after enable before soft-start, in cycles.
  localparam int unsigned INIT_CYCLES = 4;
  localparam int unsigned CNT_W = 24;

  typedef enum logic [2:0] {
    BFS_SHDN,
    BFS_INIT,
    BFS_SOFT,
    BFS_RUN,
    BFS_HIC_DRAIN,
    BFS_HIC_WAIT
  } bfs_state_t;
endpackage

/* File: rtl/bfs_flags_if.sv */
/*
  Interface carrying the synchronised comparator flags from the input
  synchroniser to the sequencer core. Assumes one clock domain.
*/
interface bfs_flags_if;
  logic supply_ok;
  logic bias_ok;
  logic en_on;
  logic en_deep;
  logic ss_over_feedback;
  logic prebias_high;
  logic oc_event;
  logic ov_fault;
  logic uv_fault;
  logic unreg;
  logic ot_fault;
  logic neg_trip;
  logic zero_cur;
  logic ss_pg_ok;
  logic out_pg_ok;
  logic cycle_start;

  modport src (output supply_ok, bias_ok, en_on, en_deep, ss_over_feedback, prebias_high,
    oc_event, ov_fault, uv_fault, unreg, ot_fault, neg_trip, zero_cur, ss_pg_ok,
    out_pg_ok, cycle_start);
  modport dst (input supply_ok, bias_ok, en_on, en_deep, ss_over_feedback, prebias_high,
    oc_event, ov_fault, uv_fault, unreg, ot_fault, neg_trip, zero_cur, ss_pg_ok,
    out_pg_ok, cycle_start);
endinterface

/* File: rtl/bfs_sync.sv */
/*
  Two-flop synchroniser bank for the comparator flags. Assumes the flags
  are raw comparator levels; the hysteresis itself is analog.
*/
module bfs_sync #(
  parameter int unsigned N = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [N-1:0] raw,
  output logic [N-1:0] synced
);
  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] sync;
  } bfs_sync_st_t;

  bfs_sync_st_t st_ff;
  bfs_sync_st_t nxt_st;

  // The first stage feeds only the second stage.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = raw;
    nxt_st.sync = st_ff.meta;
  end

  // Synchronous reset clears both stages to the safe (inactive) level.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign synced = st_ff.sync;
endmodule

/* File: rtl/bfs_pg_filter.sv */
/*
  Power-good deglitch filter: the output follows the input only after
  the input has held its new value for DGL cycles. Assumes a synchronous
  input level.
*/
module bfs_pg_filter #(
  parameter int unsigned DGL = bfs_pkg::DGL_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic pg_raw,
  output logic pg_filt
);
  typedef struct packed {
    logic out;
    logic [bfs_pkg::CNT_W-1:0] cnt;
  } bfs_pgf_st_t;

  bfs_pgf_st_t st_ff;
  bfs_pgf_st_t nxt_st;

  // Any return to the output value restarts the count, so short glitches never reach the pin.
  always_comb begin
    nxt_st = st_ff;
    if (pg_raw == st_ff.out) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt >= bfs_pkg::CNT_W'(DGL - 1)) begin
      nxt_st.out = pg_raw;
      nxt_st.cnt = '0;
    end else begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign pg_filt = st_ff.out;

  a_pg_rise_held: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(st_ff.out) |-> $past(pg_raw))
    else $error("Power good rose without a high input.");
endmodule

/* File: verification/bfs_stage_model.sv */
/*
  Model of the power stage: one pulse per switching cycle and the inductor
  zero-current flag. Assumes it shares the sequencer's clock and reset.
*/
module bfs_stage_model #(
  parameter int unsigned PERIOD = 10,
  parameter int unsigned ZERO_DLY = 6
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic high_gate,
  input wire logic low_gate,
  output logic pwm_cycle_start,
  output logic inductor_zero
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned ph_ff;
  int unsigned dr_ff;
  logic zero_ff;
  // The current drains only while the low side conducts, so a large ZERO_DLY makes a slow stage.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ph_ff <= 0;
      dr_ff <= 0;
      zero_ff <= 1'h1;
    end else begin
      ph_ff <= (ph_ff == PERIOD - 1) ? 0 : ph_ff + 1;
      dr_ff <= low_gate ? dr_ff + 1 : 0;
      if (high_gate) begin
        zero_ff <= 1'h0;
      end else if (dr_ff >= ZERO_DLY) begin
        zero_ff <= 1'h1;
      end
    end
  end
  // The cycle pulse stays quiet in reset so no phantom cycle is counted.
  assign pwm_cycle_start = (ph_ff == 0) && nrst;
  // The flag tracks the drained current itself, so a drain with the low side on can end.
  assign inductor_zero = zero_ff;
endmodule

/* File: verification/bfs_top_bench.sv */
/*
  Self-checking bench of the sequencer top with the stage model attached.
  Assumes shortened counts: soft-start 64 cycles, deglitch 8 cycles.
*/
module bfs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SS = 64;
  localparam int DGL = 8;
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  logic sup = 1'h0, bias = 1'h1, en = 1'h0, deep = 1'h0, ssfb = 1'h0, pre = 1'h0;
  logic oc = 1'h0, ov = 1'h0, uv = 1'h0, unr = 1'h0, ot = 1'h0, ntrip = 1'h0;
  logic sspg = 1'h0, outpg = 1'h1, dem = 1'h0, cap = 1'h0;
  logic pwm_start, izero, hg, lg, ssd, bias_on, pg, hic;
  logic [2:0] st;
  int fails = 0;
  int compares = 0;
  int n;
  logic saw;

  bfs_top #(.SS_CYC(SS), .DGL_CYC(DGL)) u_bfs_top (.sys_clk(sys_clk), .nrst(nrst),
    .clk_en(1'h1), .input_supply_ok(sup), .bias_rail_ok(bias), .enable_on(en),
    .enable_deep_low(deep), .ss_cap_present(cap), .ss_above_feedback_level(ssfb),
    .output_prebias_high(pre), .over_current(oc), .over_voltage(ov), .under_voltage(uv),
    .output_unregulated(unr), .over_temp(ot), .switch_node_neg_trip(ntrip),
    .inductor_zero(izero), .ss_pg_level_ok(sspg), .output_pg_level_ok(outpg),
    .pwm_cycle_start(pwm_start), .pwm_demand(dem), .high_gate(hg), .low_gate(lg),
    .ss_discharge(ssd), .bias_on(bias_on), .power_good_out(pg), .hiccup_active(hic),
    .seq_state(st));
  bfs_stage_model u_bfs_stage_model (.sys_clk(sys_clk), .nrst(nrst), .high_gate(hg),
    .low_gate(lg), .pwm_cycle_start(pwm_start), .inductor_zero(izero));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // Every wait ends 1 ns after an edge so inputs never move on the sampling edge.
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // A wait that runs out is a hang, so it ends the run there and then.
  task automatic wait_st(input logic [2:0] s, input int lim, output int k);
    k = 0;
    while (st !== s && k < lim) begin
      cyc(1);
      k++;
    end
    if (st !== s) begin
      fails++;
      print_verdict();
    end
  endtask

  task automatic wait_pg(input logic v, input int lim, output int k);
    k = 0;
    while (pg !== v && k < lim) begin
      cyc(1);
      k++;
    end
    if (pg !== v) begin
      fails++;
      print_verdict();
    end
  endtask

  // One over-current pulse early in a switching cycle, judged after it has gone.
  task automatic oc_pulse();
    int k;
    k = 0;
    while (pwm_start !== 1'h1 && k < 30) begin
      cyc(1);
      k++;
    end
    if (pwm_start !== 1'h1) begin
      fails++;
      print_verdict();
    end
    cyc(1);
    oc = 1'h1;
    cyc(4);
    oc = 1'h0;
    cyc(4);
    chk(hg, 1'h0);
  endtask

  task automatic t_lockout();
    en = 1'h1;
    cyc(8);
    chk(st, 3'h0);
    chk(hg, 1'h0);
    $display("test lockout done");
  endtask

  task automatic t_start();
    sup = 1'h1;
    wait_st(3'h1, 8, n);
    chk(st, 3'h1);
    wait_st(3'h2, 10, n);
    dem = 1'h1;
    cyc(6);
    chk(hg, 1'h0);
    ssfb = 1'h1;
    pre = 1'h1;
    cyc(6);
    chk(hg, 1'h0);
    pre = 1'h0;
    cyc(6);
    chk(hg, 1'h1);
    wait_st(3'h3, 200, n);
    chk(n + 18 >= SS, 1'h1);
    cyc(20);
    chk(pg, 1'h0);
    sspg = 1'h1;
    wait_pg(1'h1, 40, n);
    chk(n >= DGL, 1'h1);
    uv = 1'h1;
    cyc(4);
    uv = 1'h0;
    cyc(12);
    chk(pg, 1'h1);
    uv = 1'h1;
    wait_pg(1'h0, 30, n);
    chk(n >= DGL, 1'h1);
    uv = 1'h0;
    wait_pg(1'h1, 30, n);
    $display("test start done");
  endtask

  task automatic t_neg();
    dem = 1'h0;
    cyc(4);
    ntrip = 1'h1;
    cyc(6);
    chk(lg, 1'h1);
    ov = 1'h1;
    saw = 1'h0;
    repeat (8) begin
      cyc(1);
      saw = saw | (lg === 1'h0);
    end
    chk(saw, 1'h1);
    ov = 1'h0;
    ntrip = 1'h0;
    dem = 1'h1;
    cyc(10);
    $display("test negative limit done");
  endtask

  task automatic t_oc();
    repeat (4) oc_pulse();
    cyc(340);
    repeat (4) oc_pulse();
    cyc(10);
    chk(hic, 1'h0);
    cyc(340);
    repeat (5) oc_pulse();
    wait_st(3'h4, 20, n);
    chk(hic, 1'h1);
    chk({hg, lg, ssd}, 3'h3);
    wait_st(3'h5, 30, n);
    chk({hg, lg}, 3'h0);
    cap = 1'h1;
    wait_st(3'h2, 200, n);
    chk(n >= SS, 1'h1);
    chk(pg, 1'h0);
    wait_st(3'h3, 200, n);
    chk(n >= SS, 1'h1);
    $display("test over-current done");
  endtask

  task automatic t_ot_deep();
    wait_pg(1'h1, 40, n);
    ot = 1'h1;
    cyc(5);
    chk({hg, lg, ssd}, 3'h1);
    cyc(DGL + 8);
    chk(pg, 1'h0);
    ot = 1'h0;
    en = 1'h0;
    deep = 1'h1;
    cyc(5);
    chk({bias_on, ssd}, 3'h1);
    chk(st, 3'h0);
    $display("test thermal and deep done");
  endtask

  initial begin
    cyc(4);
    nrst = 1'h1;
    cyc(2);
    t_lockout();
    t_start();
    t_neg();
    t_oc();
    t_ot_deep();
    print_verdict();
  end
endmodule
